// *** src/scs_pkg.sv ***
package scs_pkg;

  // register byte offsets on the bus
  localparam logic [3:0] REG_OSC_CTRL = 4'h0;
  localparam logic [3:0] REG_SEC_TIMER = 4'h4;
  localparam logic [3:0] REG_PM_STATUS = 4'h8;

  // oscillator_control field positions
  localparam int IDLE_BIT = 7;
  localparam int READY_BIT = 3;
  localparam int SEL_HI = 1;
  localparam int SEL_LO = 0;

  // secondary_timer_control field positions
  localparam int SEC_EN_BIT = 3;
  localparam int SEC_ACT_BIT = 6;

  // reset values
  localparam logic IDLE_RST = 1'h0;
  localparam logic [1:0] SEL_RST = 2'h0;
  localparam logic SEC_EN_RST = 1'h0;

  // clock_source_select codes
  localparam logic [1:0] SEL_DEFAULT = 2'h0;
  localparam logic [1:0] SEL_SEC = 2'h1;
  localparam logic [1:0] SEL_PRI = 2'h2;
  localparam logic [1:0] SEL_RC = 2'h3;

  // primary_mode_config encoding of crystal_oscillator_mode
  localparam logic [1:0] CRYSTAL_MODE = 2'h0;

  // switch and start-up counts, in source clock cycles
  localparam int OLD_EDGES = 2;
  localparam int NEW_EDGES = 3;
  localparam int OST_CYCLES = 1024;

  typedef enum logic [1:0] {SRC_RC, SRC_PRI, SRC_SEC} scs_src_e;
  typedef enum logic [1:0] {PM_RUN, PM_IDLE, PM_SLEEP} scs_pm_e;
  typedef enum logic [1:0] {SW_STEADY, SW_OLD, SW_NEW} scs_sw_e;

endpackage

// *** src/scs_clock_switch.sv ***
// Functional notes
// [RQ1] select codes 11 rc, 10 primary, 01 secondary
// [RQ2] code 00 follows default source config bit
// [RQ3] every reset clears the source select field
// [RQ4] rc clocks device until configuration loaded
// [RQ5] select write moves clock after transition
// [RQ6] glitch-free: two old, three-four new cycles
// [RQ7] secondary ignored while its oscillator disabled
// [RQ8] software starts secondary before sleep
// [RQ9] ready flag set once start-up timer expired
// [RQ10] ready resets 0 for crystal with two-speed
// [RQ11] at most one source flag set
// [RQ12] idle select: 1 idle, 0 full sleep
// [RQ13] unimplemented control bits read zero
// [RQ14] primary runs only in run or primary idle
// [RQ15] secondary clocks device in secondary modes
// [RQ16] rc output used directly as device clock
// [RQ17] full sleep stops all device clock sources; here the secondary keeps running while enabled, and rc while two-speed is set
// [RQ18] rc stays on for watchdog or monitor
// [RQ19] idle select sampled at sleep instruction
// [RQ20] crystal start-up counts 1024 oscillator cycles
// [RQ21] device clock held inactive during switch
// [RQ22] switch pends until new source available
//
// Local design decisions: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module scs_clock_switch
  import scs_pkg::*;
#(
  parameter int OST_COUNT = OST_CYCLES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // avalon-mm slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // oscillator outputs, sampled as pins
  input wire logic primary_osc_in,
  input wire logic secondary_osc_in,
  input wire logic rc_osc_in,
  // configuration pins
  input wire logic config_loaded,
  input wire logic default_source_config,
  input wire logic [1:0] primary_mode_config,
  input wire logic two_speed_enable,
  input wire logic watchdog_enable,
  input wire logic failsafe_enable,
  // core events
  input wire logic sleep_exec,
  input wire logic wake_event,
  // oscillator run controls
  output logic primary_osc_run,
  output logic secondary_osc_run,
  output logic rc_osc_run,
  // device clock enables and state
  output logic sys_clk_en,
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic [1:0] power_mode,
  output logic [1:0] active_source
);

  localparam int NP = 10;
  localparam int OW = $clog2(OST_COUNT + 1);

  // two-flop synchronisers plus an edge stage for the three sources
  logic [NP-1:0] meta_r;
  logic [NP-1:0] sync_r;
  logic [2:0] osc_d_r;
  always_ff @(posedge core_clk) begin
    meta_r <= {primary_osc_in, secondary_osc_in, rc_osc_in, config_loaded, default_source_config,
               primary_mode_config, two_speed_enable, watchdog_enable, failsafe_enable};
    sync_r <= meta_r;
    osc_d_r <= sync_r[NP-1:NP-3];
  end

  logic cfg_s;
  logic dflt_s;
  logic crystal_s;
  logic two_speed_s;
  logic wdt_s;
  logic fscm_s;
  logic [2:0] rise;
  assign cfg_s = sync_r[6];
  assign dflt_s = sync_r[5];
  assign crystal_s = (sync_r[4:3] == CRYSTAL_MODE);
  assign two_speed_s = sync_r[2];
  assign wdt_s = sync_r[1];
  assign fscm_s = sync_r[0];
  assign rise = sync_r[NP-1:NP-3] & ~osc_d_r; // {pri, sec, rc}

  // select code to source
  function automatic scs_src_e src_of_code(input logic [1:0] code, input logic dflt);
    case (code)
      SEL_RC: src_of_code = SRC_RC; // RQ1
      SEL_PRI: src_of_code = SRC_PRI; // RQ1
      SEL_SEC: src_of_code = SRC_SEC; // RQ1
      default: src_of_code = dflt ? SRC_PRI : SRC_RC; // RQ2
    endcase
  endfunction

  // rising edge of a given source, taken straight from the sampled output
  function automatic logic edge_of(input scs_src_e src, input logic [2:0] r);
    case (src)
      SRC_PRI: edge_of = r[2];
      SRC_SEC: edge_of = r[1];
      default: edge_of = r[0]; // RQ16
    endcase
  endfunction

  // state
  logic idle_sel_r, idle_sel_nxt;
  logic [1:0] sel_r, sel_nxt;
  logic sec_en_r, sec_en_nxt;
  scs_src_e cur_src_r, cur_src_nxt;
  scs_src_e new_src_r, new_src_nxt;
  scs_sw_e sw_r, sw_nxt;
  logic [1:0] edge_cnt_r, edge_cnt_nxt;
  scs_pm_e pm_r, pm_nxt;
  logic [OW-1:0] ost_cnt_r, ost_cnt_nxt;
  logic ost_done_r, ost_done_nxt;
  logic pri_run_d_r;
  logic ack_r, ack_nxt;
  logic [31:0] rdata_r, rdata_nxt;

  scs_src_e want;
  logic avail;
  logic ready_flag;
  logic sec_active;
  logic pri_run;
  logic old_edge;
  logic new_edge;
  logic req;

  assign req = avs_read | avs_write;
  assign old_edge = edge_of(cur_src_r, rise);
  assign new_edge = edge_of(new_src_r, rise);
  assign ready_flag = ost_done_r & (cur_src_r == SRC_PRI); // RQ9 RQ11
  assign sec_active = (cur_src_r == SRC_SEC); // RQ11

  // primary stops outside run, except primary idle; sleep stops it too
  always_comb begin
    pri_run = 1'b0;
    if (cfg_s) begin
      case (pm_r)
        PM_RUN: pri_run = (cur_src_r == SRC_PRI) || (want == SRC_PRI) ||
                          (sw_r != SW_STEADY && new_src_r == SRC_PRI); // RQ14
        PM_IDLE: pri_run = (cur_src_r == SRC_PRI); // RQ14
        default: pri_run = 1'b0; // RQ17
      endcase
    end
  end

  // target source and whether it is ready to take over
  always_comb begin
    want = cfg_s ? src_of_code(sel_r, dflt_s) : SRC_RC; // RQ4
    if (want == SRC_SEC && !sec_en_r) begin
      want = cur_src_r; // RQ7
    end
    case (want)
      SRC_PRI: avail = pri_run & ost_done_r; // RQ22
      SRC_SEC: avail = sec_en_r; // RQ22
      default: avail = 1'b1;
    endcase
  end

  // next-state: registers, switch sequencer, power mode, start-up timer
  always_comb begin
    idle_sel_nxt = idle_sel_r;
    sel_nxt = sel_r;
    sec_en_nxt = sec_en_r;
    cur_src_nxt = cur_src_r;
    new_src_nxt = new_src_r;
    sw_nxt = sw_r;
    edge_cnt_nxt = edge_cnt_r;
    pm_nxt = pm_r;
    ost_cnt_nxt = ost_cnt_r;
    ost_done_nxt = ost_done_r;
    ack_nxt = req & ~ack_r;
    rdata_nxt = rdata_r;

    // register write lands on the edge that ends the wait
    if (avs_write && ack_r && avs_byteenable[0]) begin
      case (avs_address)
        REG_OSC_CTRL: begin
          idle_sel_nxt = avs_writedata[IDLE_BIT];
          sel_nxt = avs_writedata[SEL_HI:SEL_LO]; // RQ5
        end
        REG_SEC_TIMER: sec_en_nxt = avs_writedata[SEC_EN_BIT];
        default: ;
      endcase
    end

    // read data captured one edge ahead so it stands when wait drops
    if (avs_read && !ack_r) begin
      case (avs_address)
        REG_OSC_CTRL: rdata_nxt = {24'h0, idle_sel_r, 3'h0, ready_flag, 1'h0, sel_r}; // RQ13
        REG_SEC_TIMER: rdata_nxt = {25'h0, sec_active, 2'h0, sec_en_r, 3'h0};
        REG_PM_STATUS: rdata_nxt = {27'h0, (sw_r != SW_STEADY), pm_r, cur_src_r};
        default: rdata_nxt = 32'h0;
      endcase
    end

    // switch: stop on old edges, then count new edges before handing over
    case (sw_r)
      SW_STEADY: begin
        if (want != cur_src_r && avail && pm_r != PM_SLEEP) begin // RQ22
          new_src_nxt = want;
          sw_nxt = SW_OLD;
          edge_cnt_nxt = 2'h0;
        end
      end
      SW_OLD: begin
        if (old_edge) begin
          edge_cnt_nxt = edge_cnt_r + 2'h1;
          if (edge_cnt_r == 2'(OLD_EDGES - 1)) begin // RQ6
            sw_nxt = SW_NEW;
            edge_cnt_nxt = 2'h0;
          end
        end
      end
      SW_NEW: begin
        if (new_edge) begin
          edge_cnt_nxt = edge_cnt_r + 2'h1;
          if (edge_cnt_r == 2'(NEW_EDGES - 1)) begin // RQ6
            cur_src_nxt = new_src_r; // RQ5
            sw_nxt = SW_STEADY;
            edge_cnt_nxt = 2'h0;
          end
        end
      end
      default: sw_nxt = SW_STEADY;
    endcase

    // sleep instruction samples idle select at that moment
    case (pm_r)
      PM_RUN: begin
        if (sleep_exec) begin
          pm_nxt = idle_sel_r ? PM_IDLE : PM_SLEEP; // RQ12 RQ19
        end
      end
      PM_IDLE, PM_SLEEP: begin
        if (wake_event) begin
          pm_nxt = PM_RUN;
        end
      end
      default: pm_nxt = PM_RUN;
    endcase

    // start-up timer: crystal needs counted edges, driven clock is ready at once
    if (!cfg_s || !crystal_s) begin
      ost_done_nxt = cfg_s | ~(crystal_s & two_speed_s); // RQ10 until configuration loaded
      ost_cnt_nxt = '0;
    end else if (!pri_run) begin
      if (pri_run_d_r) begin
        ost_done_nxt = 1'b0; // restart after the oscillator was stopped
        ost_cnt_nxt = '0;
      end
    end else if (!ost_done_r && rise[2]) begin
      ost_cnt_nxt = ost_cnt_r + OW'(1);
      if (ost_cnt_r == OW'(OST_COUNT - 1)) begin
        ost_done_nxt = 1'b1; // RQ20 RQ9
      end
    end
  end

  // register everything; synchronous active-low reset
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      idle_sel_r <= IDLE_RST;
      sel_r <= SEL_RST; // RQ3
      sec_en_r <= SEC_EN_RST;
      cur_src_r <= SRC_RC; // RQ4
      new_src_r <= SRC_RC;
      sw_r <= SW_STEADY;
      edge_cnt_r <= 2'h0;
      pm_r <= PM_RUN;
      ost_cnt_r <= '0;
      ost_done_r <= ~(crystal_s & two_speed_s); // RQ10
      pri_run_d_r <= 1'b0;
      ack_r <= 1'b0;
      rdata_r <= 32'h0;
    end else begin
      idle_sel_r <= idle_sel_nxt;
      sel_r <= sel_nxt;
      sec_en_r <= sec_en_nxt;
      cur_src_r <= cur_src_nxt;
      new_src_r <= new_src_nxt;
      sw_r <= sw_nxt;
      edge_cnt_r <= edge_cnt_nxt;
      pm_r <= pm_nxt;
      ost_cnt_r <= ost_cnt_nxt;
      ost_done_r <= ost_done_nxt;
      pri_run_d_r <= pri_run;
      ack_r <= ack_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // bus answers one cycle after the request is seen
  assign avs_waitrequest = req & ~ack_r;
  assign avs_readdata = rdata_r;

  // oscillator controls; rc kept alive for watchdog and monitor even in sleep
  assign primary_osc_run = pri_run;
  assign secondary_osc_run = sec_en_r; // RQ15
  assign rc_osc_run = !cfg_s || wdt_s || fscm_s || two_speed_s || // RQ4 RQ18
                      (pm_r != PM_SLEEP && (cur_src_r == SRC_RC || want == SRC_RC ||
                      (sw_r != SW_STEADY && new_src_r == SRC_RC))); // RQ16

  // device clock pulses only from a settled source, never mid-switch
  assign sys_clk_en = old_edge && sw_r == SW_STEADY && pm_r != PM_SLEEP; // RQ21 RQ17
  assign cpu_clk_en = sys_clk_en && pm_r == PM_RUN; // RQ12
  assign periph_clk_en = sys_clk_en;
  assign power_mode = pm_r;
  assign active_source = cur_src_r;

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  sequence last_new_edge;
    sw_r == SW_NEW && new_edge && edge_cnt_r == 2'(NEW_EDGES - 1);
  endsequence

  sequence switch_start;
    sw_r == SW_STEADY ##1 sw_r == SW_OLD;
  endsequence

  a_switch_quiet: assert property (sw_r != SW_STEADY |-> !sys_clk_en) // RQ21
    else $error("device clock pulsed during a source switch");
  a_switch_handover: assert property (last_new_edge |=> cur_src_r == $past(new_src_r) && sw_r == SW_STEADY) // RQ5
    else $error("new source not taken over after its counted edges");
  a_old_edges: assert property (switch_start |-> edge_cnt_r == 2'h0 ##0 (sw_r == SW_OLD)[*1]) // RQ6
    else $error("switch did not start counting old edges from zero");
  a_sec_ignored: assert property (switch_start ##0 new_src_r == SRC_SEC |-> $past(sec_en_r)) // RQ7
    else $error("switch to secondary while its oscillator is disabled");
  a_powerup_rc: assert property (!cfg_s |-> cur_src_r == SRC_RC && rc_osc_run) // RQ4
    else $error("rc not clocking before configuration load");
  a_reset_sel: assert property ($past(!rstn) |-> sel_r == SEL_DEFAULT) // RQ3
    else $error("source select not cleared by reset");
  a_idle_enter: assert property (pm_r == PM_RUN && sleep_exec && idle_sel_r |=> pm_r == PM_IDLE) // RQ12
    else $error("idle not entered with idle select set");
  a_sleep_enter: assert property (pm_r == PM_RUN && sleep_exec && !idle_sel_r |=> pm_r == PM_SLEEP) // RQ19
    else $error("sleep not entered with idle select clear");
  a_sleep_stops: assert property (pm_r == PM_SLEEP |-> !sys_clk_en && !primary_osc_run) // RQ17
    else $error("clock running in full sleep");
  a_pri_stopped: assert property (pm_r != PM_RUN && cur_src_r != SRC_PRI |-> !primary_osc_run) // RQ14
    else $error("primary running in a non-primary power-managed mode");
  a_rc_kept: assert property (wdt_s || fscm_s |-> rc_osc_run) // RQ18
    else $error("rc stopped while watchdog or monitor needs it");
  a_flags_excl: assert property (!(ready_flag && sec_active)) // RQ11
    else $error("both source flags set");
  a_ready_timer: assert property (crystal_s && pri_run && !ost_done_r |-> !ready_flag && ost_cnt_r < OW'(OST_COUNT)) // RQ20
    else $error("primary ready before start-up count finished");
  a_rsvd_zero: assert property (avs_read && !ack_r && avs_address == REG_OSC_CTRL |=> // RQ13
    avs_readdata[6:4] == 3'h0 && avs_readdata[2] == 1'h0)
    else $error("unimplemented control bits read nonzero");

endmodule
`default_nettype wire

// *** bench/scs_osc_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module scs_osc_model #(
  parameter int HALF = 2
) (
  // reference clock
  input wire logic core_clk,
  // run enable from the block
  input wire logic run,
  // oscillator output
  output logic osc_out
);
  logic [7:0] cnt_r = 8'h0;
  logic [7:0] cnt_nxt;
  logic osc_r = 1'b0;
  logic osc_nxt;

  // a stopped oscillator sits low, like a disabled feedback inverter
  always_comb begin
    cnt_nxt = cnt_r + 8'h1;
    osc_nxt = osc_r;
    if (!run) begin
      cnt_nxt = 8'h0;
      osc_nxt = 1'b0;
    end else if (cnt_r == 8'(HALF - 1)) begin
      cnt_nxt = 8'h0;
      osc_nxt = ~osc_r;
    end
  end

  // registers only
  always_ff @(posedge core_clk) begin
    cnt_r <= cnt_nxt;
    osc_r <= osc_nxt;
  end

  assign osc_out = osc_r;
endmodule
`default_nettype wire

// *** bench/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
  import scs_pkg::*;
  localparam int OSTN = 4;
  localparam int PH = 2;
  localparam int SH = 7;
  localparam int RH = 5;
  logic core_clk, rstn, avs_read, avs_write, avs_waitrequest;
  logic [3:0] avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic primary_osc_in, secondary_osc_in, rc_osc_in, config_loaded, default_source_config;
  logic [1:0] primary_mode_config, power_mode, active_source;
  logic two_speed_enable, watchdog_enable, failsafe_enable, sleep_exec, wake_event;
  logic primary_osc_run, secondary_osc_run, rc_osc_run, sys_clk_en, cpu_clk_en, periph_clk_en;
  int mismatches, checked;

  // short start-up count keeps the run brief
  scs_clock_switch #(.OST_COUNT(OSTN)) uut (
    .core_clk, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .primary_osc_in, .secondary_osc_in, .rc_osc_in,
    .config_loaded, .default_source_config, .primary_mode_config, .two_speed_enable,
    .watchdog_enable, .failsafe_enable, .sleep_exec, .wake_event, .primary_osc_run,
    .secondary_osc_run, .rc_osc_run, .sys_clk_en, .cpu_clk_en, .periph_clk_en,
    .power_mode, .active_source
  );
  // sources at three different speeds
  scs_osc_model #(.HALF(PH)) pri_osc (.core_clk, .run(primary_osc_run), .osc_out(primary_osc_in));
  scs_osc_model #(.HALF(SH)) sec_osc (.core_clk, .run(secondary_osc_run), .osc_out(secondary_osc_in));
  scs_osc_model #(.HALF(RH)) rc_osc (.core_clk, .run(rc_osc_run), .osc_out(rc_osc_in));

  // 100 mhz clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  // one access, held until waitrequest is seen low before a rising edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
    logic w;
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= {24'h0, d};
    do begin
      @(negedge core_clk);
      w = avs_waitrequest;
      rd = avs_readdata;
      n++;
      @(posedge core_clk);
    end while (w !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // every access is answered in its second cycle
    chk(n, 2, "bus answer");
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp, input string what);
    bus(1'b0, a, 8'h0);
    chk(rd, {24'h0, exp}, what);
  endtask

  // pause must show no device clock and last at least the old and new edge spans
  task automatic wait_src(input logic [1:0] s, input int oh, input int nh);
    int n;
    int lp;
    n = 0;
    lp = 0;
    @(posedge core_clk);
    // a pending switch keeps the old clock, so the pause runs from its last pulse
    while (active_source !== s && n < 400) begin
      @(negedge core_clk);
      n++;
      if (sys_clk_en === 1'b1 && active_source !== s) lp = n;
    end
    chk(active_source, s, "source");
    chk(n - lp > 4 * nh, 1, "clock during switch");
    chk(n - lp >= 2 * oh + 4 * nh - 2 && n < 150, 1, "pause length");
  endtask

  task automatic switch_to(input logic [7:0] v, input logic [1:0] s, input int oh, input int nh);
    bus(1'b1, REG_OSC_CTRL, v);
    wait_src(s, oh, nh);
  endtask

  task automatic pulse(input logic slp);
    @(posedge core_clk);
    sleep_exec <= slp;
    wake_event <= ~slp;
    @(posedge core_clk);
    sleep_exec <= 1'b0;
    wake_event <= 1'b0;
    @(negedge core_clk);
  endtask

  task automatic t_powerup;
    repeat (30) @(negedge core_clk);
    chk(active_source, SRC_RC, "rc before config");
    rd_chk(REG_OSC_CTRL, 8'h00, "control after reset");
    @(posedge core_clk);
    config_loaded <= 1'b1;
    wait_src(SRC_PRI, RH, PH);
    rd_chk(REG_OSC_CTRL, 8'h08, "ready with primary");
    $display("test powerup done");
  endtask

  task automatic t_codes;
    switch_to(8'h03, SRC_RC, PH, RH);
    switch_to(8'h02, SRC_PRI, RH, PH);
    switch_to(8'hff, SRC_RC, PH, RH);
    rd_chk(REG_OSC_CTRL, 8'h83, "unused bits");
    switch_to(8'h00, SRC_PRI, RH, PH);
    $display("test codes done");
  endtask

  task automatic t_secondary;
    bus(1'b1, REG_OSC_CTRL, 8'h01);
    repeat (80) @(negedge core_clk);
    chk(active_source, SRC_PRI, "secondary while disabled");
    rd_chk(REG_SEC_TIMER, 8'h00, "secondary off");
    chk(secondary_osc_run, 1'b0, "secondary stopped");
    bus(1'b1, REG_SEC_TIMER, 8'h08);
    wait_src(SRC_SEC, PH, SH);
    chk(secondary_osc_run, 1'b1, "secondary running");
    rd_chk(REG_SEC_TIMER, 8'h48, "secondary flag");
    rd_chk(REG_OSC_CTRL, 8'h01, "ready clear");
    switch_to(8'h02, SRC_PRI, SH, PH);
    $display("test secondary done");
  endtask

  task automatic t_sleep;
    int c;
    int p;
    c = 0;
    p = 0;
    bus(1'b1, REG_OSC_CTRL, 8'h82);
    pulse(1'b1);
    chk(power_mode, PM_IDLE, "idle entered");
    repeat (40) begin
      @(negedge core_clk);
      c += int'(cpu_clk_en === 1'b1);
      p += int'(periph_clk_en === 1'b1);
    end
    chk(c, 0, "cpu clock in idle");
    chk(p > 0, 1, "peripheral clock in idle");
    chk(primary_osc_run, 1'b1, "primary in idle");
    pulse(1'b0);
    chk(power_mode, PM_RUN, "woken");
    bus(1'b1, REG_OSC_CTRL, 8'h02);
    pulse(1'b1);
    chk(power_mode, PM_SLEEP, "sleep entered");
    c = 0;
    repeat (40) begin
      @(negedge core_clk);
      c += int'(sys_clk_en === 1'b1);
    end
    chk(c, 0, "clock in sleep");
    chk({primary_osc_run, rc_osc_run}, 2'h0, "sources in sleep");
    @(posedge core_clk);
    watchdog_enable <= 1'b1;
    repeat (6) @(negedge core_clk);
    chk(rc_osc_run, 1'b1, "rc kept for watchdog");
    pulse(1'b0);
    chk(power_mode, PM_RUN, "woken from sleep");
    @(posedge core_clk);
    watchdog_enable <= 1'b0;
    repeat (60) @(negedge core_clk);
    $display("test sleep done");
  endtask

  task automatic t_refuse;
    rd_chk(4'hc, 8'h00, "unmapped read");
    bus(1'b1, REG_PM_STATUS, 8'hff);
    rd_chk(REG_PM_STATUS, 8'h01, "status read only");
    @(posedge core_clk);
    avs_byteenable <= 4'he;
    bus(1'b1, REG_OSC_CTRL, 8'h03);
    avs_byteenable <= 4'hf;
    rd_chk(REG_OSC_CTRL, 8'h0a, "masked write");
    $display("test refuse done");
  endtask

  task automatic t_rereset;
    @(posedge core_clk);
    rstn <= 1'b0;
    default_source_config <= 1'b0;
    primary_mode_config <= 2'h1;
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (30) @(negedge core_clk);
    chk(active_source, SRC_RC, "rc after reset");
    rd_chk(REG_OSC_CTRL, 8'h00, "control cleared");
    rd_chk(REG_SEC_TIMER, 8'h00, "secondary cleared");
    // driven clock needs no start-up count, so ready follows the switch at once
    switch_to(8'h02, SRC_PRI, RH, PH);
    rd_chk(REG_OSC_CTRL, 8'h0a, "ready driven clock");
    $display("test rereset done");
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // main sequence; crystal primary is the default source
  initial begin
    mismatches = 0;
    checked = 0;
    rstn = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    config_loaded = 1'b0;
    default_source_config = 1'b1;
    primary_mode_config = CRYSTAL_MODE;
    two_speed_enable = 1'b0;
    watchdog_enable = 1'b0;
    failsafe_enable = 1'b0;
    sleep_exec = 1'b0;
    wake_event = 1'b0;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    t_powerup;
    t_codes;
    t_secondary;
    t_sleep;
    t_refuse;
    t_rereset;
    report_and_stop;
  end

  // cuts a hang short, well beyond the thousand or so cycles expected
  initial begin
    #400000;
    mismatches++;
    report_and_stop;
  end
endmodule
`default_nettype wire
